// ---- design/timer0_ctrl.sv ----
// timer zero flags, clock source select, prescaler and sync hold logic
`timescale 1ns/1ps

module timer0_ctrl
    import timer0_pkg::*;
#(
    parameter int PRESCALE_BITS = PRESCALE_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic global_irq_enable,
    input wire logic t0_compare_vector_ack,
    input wire logic t0_overflow_vector_ack,
    input wire logic [7:0] t0_count,
    input wire logic [7:0] t0_compare_value,
    input wire logic t0_overflow_evt,
    input wire logic t0_pwm_mode,
    input wire logic t0_count_down,
    input wire logic timer_osc_in_pin,
    output logic t0_count_enable,
    output logic t0_prescaler_hold,
    output logic other_prescaler_reset,
    output logic timer_osc_pins_detached,
    output logic t0_compare_irq,
    output logic t0_overflow_irq,
    output logic irq
);

    logic [1:0] flags_r;
    logic [1:0] mask_r;
    logic sync_hold_r;
    logic t0_psr_r;
    logic other_psr_r;
    logic t0_async_select_r;
    logic [2:0] clksel_r;
    logic [PRESCALE_BITS-1:0] presc_r;
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic osc_lvl_r;
    logic osc_rise;
    logic src_tick;
    logic presc_rst;
    logic tap;
    logic count_en_r;
    logic down_prev_r;
    logic cmp_evt;
    logic ovf_evt;
    logic [1:0] evt;
    logic [1:0] pend_r;
    logic [1:0] xfer_r [FLAG_SYNC_CYCLES];
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [1:0] w1c;
    logic wr_flags;
    logic wr_sfc;
    logic [7:0] rd_mux;

    // prescaler tap decode
    function automatic logic tap_hit(input logic [PRESCALE_BITS-1:0] cnt, input logic [2:0] sel);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            SEL_STOP: hit = 1'b0;
            SEL_DIV1: hit = 1'b1;
            SEL_DIV8: hit = &cnt[2:0];
            SEL_DIV32: hit = &cnt[4:0];
            SEL_DIV64: hit = &cnt[5:0];
            SEL_DIV128: hit = &cnt[6:0];
            SEL_DIV256: hit = &cnt[7:0];
            SEL_DIV1024: hit = &cnt[9:0];
        endcase
        return hit;
    endfunction

    // oscillator pin synchroniser, three stages
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
            osc_lvl_r <= 1'b0;
        end
        else
        begin
            osc_s1_r <= timer_osc_in_pin;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            if (osc_s2_r == osc_s3_r)
            begin
                osc_lvl_r <= osc_s3_r;
            end
        end
    end

    assign osc_rise = (osc_s2_r == osc_s3_r) && osc_s3_r && !osc_lvl_r;

    // source clock: system clock by default, oscillator pin when async
    assign src_tick = t0_async_select_r ? osc_rise : 1'b1;
    assign timer_osc_pins_detached = t0_async_select_r;
    assign presc_rst = t0_psr_r;

    // prescaler counter
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            presc_r <= '0;
        end
        else if (presc_rst)
        begin
            presc_r <= '0;
        end
        else if (src_tick)
        begin
            presc_r <= presc_r + 1'b1;
        end
    end

    assign tap = src_tick && !presc_rst && tap_hit(presc_r, clksel_r);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_en_r <= 1'b0;
        end
        else
        begin
            count_en_r <= tap;
        end
    end

    assign t0_count_enable = count_en_r;
    assign t0_prescaler_hold = t0_psr_r;
    assign other_prescaler_reset = other_psr_r;

    // timer events
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            down_prev_r <= 1'b0;
        end
        else
        begin
            down_prev_r <= t0_count_down;
        end
    end

    assign cmp_evt = count_en_r && (t0_count == t0_compare_value);
    assign ovf_evt = t0_pwm_mode
        ? (down_prev_r && !t0_count_down && t0_count == PWM_BOTTOM)
        : t0_overflow_evt;

    // both events, compare in the upper bit
    assign evt = {cmp_evt, ovf_evt};

    // async flag crossing: wait one timer cycle, then three processor cycles
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend_r <= 2'h0;
            for (int i = 0; i < FLAG_SYNC_CYCLES; i++)
            begin
                xfer_r[i] <= 2'h0;
            end
        end
        else
        begin
            if (!t0_async_select_r)
            begin
                // nothing stays pending across a switch to async
                pend_r <= 2'h0;
                xfer_r[0] <= 2'h0;
            end
            else if (osc_rise)
            begin
                pend_r <= evt;
                xfer_r[0] <= pend_r;
            end
            else
            begin
                pend_r <= pend_r | evt;
                xfer_r[0] <= 2'h0;
            end
            for (int i = 1; i < FLAG_SYNC_CYCLES; i++)
            begin
                xfer_r[i] <= xfer_r[i-1];
            end
        end
    end

    // flag source by clock mode
    assign flag_set = t0_async_select_r ? xfer_r[FLAG_SYNC_CYCLES-1]
        : evt;

    // flag register, set wins over clear
    assign wr_flags = wr_en && (addr == ADDR_FLAGS);
    assign w1c = wr_flags ? {wdata[BIT_CMP], wdata[BIT_OVF]} : 2'h0;
    assign flag_clr = w1c | {t0_compare_vector_ack, t0_overflow_vector_ack};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flags_r <= RST_FLAGS[1:0];
        end
        else
        begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    // interrupt requests
    assign t0_compare_irq = global_irq_enable && mask_r[BIT_CMP] && flags_r[BIT_CMP];
    assign t0_overflow_irq = global_irq_enable && mask_r[BIT_OVF] && flags_r[BIT_OVF];
    assign irq = t0_compare_irq || t0_overflow_irq;

    // mask, async select and clock select registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mask_r <= RST_MASK[1:0];
            t0_async_select_r <= RST_ASYNC[BIT_ASYNC_SEL];
            clksel_r <= RST_CLKSEL;
        end
        else if (wr_en)
        begin
            if (addr == ADDR_MASK)
            begin
                mask_r <= {wdata[BIT_CMP], wdata[BIT_OVF]};
            end
            if (addr == ADDR_ASYNC)
            begin
                t0_async_select_r <= wdata[BIT_ASYNC_SEL];
            end
            if (addr == ADDR_CLKSEL)
            begin
                clksel_r <= wdata[CLKSEL_LSB +: CLKSEL_W];
            end
        end
    end

    // special function control: sync hold and prescaler resets
    assign wr_sfc = wr_en && (addr == ADDR_SFC);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync_hold_r <= RST_SFC[BIT_SYNC_HOLD];
            t0_psr_r <= RST_SFC[BIT_T0_PSR];
            other_psr_r <= RST_SFC[BIT_OTHER_PSR];
        end
        else if (wr_sfc)
        begin
            sync_hold_r <= wdata[BIT_SYNC_HOLD];
            if (!wdata[BIT_SYNC_HOLD])
            begin
                t0_psr_r <= 1'b0;
                other_psr_r <= 1'b0;
            end
            else
            begin
                t0_psr_r <= wdata[BIT_T0_PSR];
                other_psr_r <= wdata[BIT_OTHER_PSR];
            end
            if (!sync_hold_r && !wdata[BIT_SYNC_HOLD])
            begin
                t0_psr_r <= wdata[BIT_T0_PSR];
                other_psr_r <= wdata[BIT_OTHER_PSR];
            end
        end
        else if (!sync_hold_r)
        begin
            other_psr_r <= 1'b0;
            if (!t0_async_select_r || osc_rise)
            begin
                t0_psr_r <= 1'b0;
            end
        end
    end

    // register read, data one cycle after strobe
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (addr)
            ADDR_FLAGS: rd_mux = {6'h00, flags_r};
            ADDR_MASK: rd_mux = {6'h00, mask_r};
            ADDR_SFC: rd_mux = {sync_hold_r, 5'h00, t0_psr_r, other_psr_r};
            ADDR_ASYNC: rd_mux = {4'h0, t0_async_select_r, 3'h0};
            ADDR_CLKSEL: rd_mux = {5'h00, clksel_r};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else if (rd_en)
        begin
            rdata <= rd_mux;
        end
        else
        begin
            rdata <= 8'h00;
        end
    end

endmodule

// ---- design/timer0_pkg.sv ----
// constants for the timer zero flag, clock select and prescaler control block
package timer0_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_FLAGS = 8'h36;
    localparam logic [7:0] ADDR_MASK = 8'h37;
    localparam logic [7:0] ADDR_SFC = 8'h20;
    localparam logic [7:0] ADDR_ASYNC = 8'h30;
    localparam logic [7:0] ADDR_CLKSEL = 8'h33;
    // field positions
    localparam int BIT_OVF = 0;
    localparam int BIT_CMP = 1;
    localparam int BIT_OTHER_PSR = 0;
    localparam int BIT_T0_PSR = 1;
    localparam int BIT_SYNC_HOLD = 7;
    localparam int BIT_ASYNC_SEL = 3;
    localparam int CLKSEL_LSB = 0;
    localparam int CLKSEL_W = 3;
    // reset values
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_SFC = 8'h00;
    localparam logic [7:0] RST_ASYNC = 8'h00;
    localparam logic [2:0] RST_CLKSEL = 3'h0;
    // clock select codes
    localparam logic [2:0] SEL_STOP = 3'h0;
    localparam logic [2:0] SEL_DIV1 = 3'h1;
    localparam logic [2:0] SEL_DIV8 = 3'h2;
    localparam logic [2:0] SEL_DIV32 = 3'h3;
    localparam logic [2:0] SEL_DIV64 = 3'h4;
    localparam logic [2:0] SEL_DIV128 = 3'h5;
    localparam logic [2:0] SEL_DIV256 = 3'h6;
    localparam logic [2:0] SEL_DIV1024 = 3'h7;
    // prescaler and flag crossing
    localparam int PRESCALE_W = 10;
    localparam int FLAG_SYNC_CYCLES = 3;
    localparam logic [7:0] PWM_BOTTOM = 8'h00;
endpackage

// ---- test/test_timer0_ctrl.sv ----
// self-checking bench for the timer zero control block
`timescale 1ns/1ps
module test_timer0_ctrl
    import timer0_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, gie = 1'b0, osc = 1'b0;
    logic cack = 1'b0, oack = 1'b0, oevt = 1'b0, pwm = 1'b0, down = 1'b0, rd_q = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, cnt = 8'h00, cmpv = 8'hFF;
    logic [7:0] rdata;
    logic [31:0] rnd = 32'h28AD;
    logic cen, phold, opsr, det, cirq, oirq, irq;
    logic [7:0] expq[$];
    int n_mismatch = 0, checks_done = 0, cyc = 0, p;
    int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    timer0_ctrl dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .global_irq_enable(gie), .t0_compare_vector_ack(cack),
        .t0_overflow_vector_ack(oack), .t0_count(cnt), .t0_compare_value(cmpv),
        .t0_overflow_evt(oevt), .t0_pwm_mode(pwm), .t0_count_down(down),
        .timer_osc_in_pin(osc), .t0_count_enable(cen), .t0_prescaler_hold(phold),
        .other_prescaler_reset(opsr), .timer_osc_pins_detached(det),
        .t0_compare_irq(cirq), .t0_overflow_irq(oirq), .irq(irq)
    );
    initial forever #2 clk = ~clk;
    always #21 osc <= ~osc;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask
    // cycles between two tick pulses, 0 if none
    task automatic period(output int q);
        int f;
        f = 0;
        q = 0;
        // skip the tick launched before the prescaler reset took hold
        repeat (2) @(posedge clk);
        for (int i = 1; i < 2200 && q == 0; i++)
        begin
            @(posedge clk);
            if (cen && f != 0)
                q = i - f;
            else if (cen)
                f = i;
        end
    endtask
    task automatic pulse_ovf();
        @(posedge clk);
        oevt <= 1'b1;
        @(posedge clk);
        oevt <= 1'b0;
    endtask
    // read results checked in the cycle after the strobe
    always @(posedge clk)
    begin
        cyc++;
        if (rd_q)
            chk("rdata", 16'(expq.pop_front()), 16'(rdata));
        rd_q <= rd_en;
        if (cyc == 40000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_FLAGS, RST_FLAGS);
        rd(ADDR_ASYNC, RST_ASYNC);
        rd(8'h40, 8'h00);
        wr(ADDR_MASK, 8'h03);
        wr(ADDR_CLKSEL, 8'(SEL_DIV1));
        rnd = lfsr(rnd);
        @(posedge clk);
        gie <= 1'b1;
        cnt <= rnd[7:0];
        cmpv <= rnd[7:0];
        repeat (3) @(posedge clk);
        cmpv <= ~rnd[7:0];
        rd(ADDR_FLAGS, 8'h02);
        chk("cmp irq", 16'(cirq), 16'h1);
        @(posedge clk);
        gie <= 1'b0;
        @(negedge clk);
        chk("irq", 16'(irq), 16'h0);
        wr(ADDR_FLAGS, 8'h01);
        rd(ADDR_FLAGS, 8'h02);
        cack <= 1'b1;
        @(posedge clk);
        cack <= 1'b0;
        gie <= 1'b1;
        rd(ADDR_FLAGS, 8'h00);
        pulse_ovf();
        @(negedge clk);
        chk("ovf irq", 16'(oirq), 16'h1);
        wr(ADDR_FLAGS, 8'h01);
        rd(ADDR_FLAGS, 8'h00);
        pwm <= 1'b1;
        cnt <= PWM_BOTTOM;
        down <= 1'b1;
        @(posedge clk);
        down <= 1'b0;
        rd(ADDR_FLAGS, 8'h01);
        oack <= 1'b1;
        @(posedge clk);
        oack <= 1'b0;
        pwm <= 1'b0;
        rd(ADDR_FLAGS, 8'h00);
        wr(ADDR_SFC, 8'h03);
        @(negedge clk);
        chk("psr", 16'(phold), 16'h1);
        @(negedge clk);
        chk("psr", 16'(phold), 16'h0);
        wr(ADDR_SFC, 8'h83);
        repeat (20) @(negedge clk);
        chk("held", 16'({phold, opsr}), 16'h3);
        wr(ADDR_SFC, 8'h00);
        @(negedge clk);
        chk("released", 16'({phold, opsr}), 16'h0);
        for (int k = 0; k < 8; k++)
        begin
            wr(ADDR_CLKSEL, 8'(k));
            wr(ADDR_SFC, 8'h02);
            period(p);
            chk("period", 16'(divs[k]), 16'(p));
        end
        wr(ADDR_CLKSEL, 8'(SEL_DIV1));
        wr(ADDR_ASYNC, 8'h08);
        @(negedge clk);
        chk("detached", 16'(det), 16'h1);
        period(p);
        chk("async tick", 16'(p > 8 && p < 13), 16'h1);
        wr(ADDR_SFC, 8'h02);
        @(negedge clk);
        chk("async psr", 16'(phold), 16'h1);
        repeat (12) @(negedge clk);
        chk("async psr done", 16'(phold), 16'h0);
        pulse_ovf();
        repeat (2) @(negedge clk);
        chk("early flag", 16'(oirq), 16'h0);
        repeat (40) @(negedge clk);
        chk("late flag", 16'(oirq), 16'h1);
        wr(ADDR_ASYNC, 8'h00);
        @(negedge clk);
        chk("detached", 16'(det), 16'h0);
        give_verdict();
    end
endmodule

// ---- test/timer0_ctrl_assertions.sv ----
// assertions for the timer zero control block
`timescale 1ns/1ps
module timer0_ctrl_assertions
    import timer0_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic global_irq_enable,
    input wire logic t0_prescaler_hold,
    input wire logic other_prescaler_reset,
    input wire logic timer_osc_pins_detached,
    input wire logic t0_compare_irq,
    input wire logic t0_overflow_irq,
    input wire logic irq
);
    logic hold_r;
    logic sfc;
    assign sfc = wr_en && addr == ADDR_SFC;
    // sync hold bit as last written
    always_ff @(posedge clk)
    begin
        if (rst)
            hold_r <= 1'b0;
        else if (sfc)
            hold_r <= wdata[BIT_SYNC_HOLD];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_cmp; t0_compare_irq |-> global_irq_enable; endproperty
    a_cmp: assert property (p_cmp) else $error("cmp irq");
    property p_ovf; t0_overflow_irq |-> global_irq_enable; endproperty
    a_ovf: assert property (p_ovf) else $error("ovf irq");
    property p_any; irq == (t0_compare_irq || t0_overflow_irq); endproperty
    a_any: assert property (p_any) else $error("irq");
    property p_pulse; sfc && wdata == 8'h03 && !hold_r && !timer_osc_pins_detached
        |=> t0_prescaler_hold ##1 !t0_prescaler_hold; endproperty
    a_pulse: assert property (p_pulse) else $error("psr pulse");
    property p_oth; other_prescaler_reset && !hold_r && !sfc |=> !other_prescaler_reset;
    endproperty
    a_oth: assert property (p_oth) else $error("other psr");
    property p_keep; hold_r && t0_prescaler_hold && !sfc |=> t0_prescaler_hold; endproperty
    a_keep: assert property (p_keep) else $error("psr keep");
    property p_rel; sfc && !wdata[BIT_SYNC_HOLD] && hold_r
        |=> !t0_prescaler_hold && !other_prescaler_reset; endproperty
    a_rel: assert property (p_rel) else $error("psr release");
    property p_det; wr_en && addr == ADDR_ASYNC
        |=> timer_osc_pins_detached == $past(wdata[BIT_ASYNC_SEL]); endproperty
    a_det: assert property (p_det) else $error("detach");
    property p_det_keep; !(wr_en && addr == ADDR_ASYNC) |=> $stable(timer_osc_pins_detached);
    endproperty
    a_det_keep: assert property (p_det_keep) else $error("detach changed");
endmodule
bind timer0_ctrl timer0_ctrl_assertions watch (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .global_irq_enable(global_irq_enable), .t0_prescaler_hold(t0_prescaler_hold),
    .other_prescaler_reset(other_prescaler_reset), .irq(irq),
    .timer_osc_pins_detached(timer_osc_pins_detached),
    .t0_compare_irq(t0_compare_irq), .t0_overflow_irq(t0_overflow_irq)
);
